// *** src/sbs_regs.vh ***
`ifndef SBS_REGS_VH
`define SBS_REGS_VH
// Printed offset 0x17 is not a multiple of four, so offsets are word indices.
`define SBS_IDX_STATUS_TWO 8'h17
`define SBS_IDX_STATUS_ONE 8'h16
`define SBS_IDX_DATA 8'h18
`define SBS_IDX_CONTROL_THREE 8'h19
`define SBS_IDX_RX_CTRL 8'h1A
`define SBS_BIT_IN_PROGRESS 0
`define SBS_BIT_BREAK 1
`define SBS_BIT_RFULL 5
`define SBS_BIT_FRAMING 1
`define SBS_BIT_NINTH 7
`define SBS_BIT_NINE 0
`define SBS_BIT_EN 1
`define SBS_RESET_STATUS 8'h00
`define SBS_RESET_DIV 16'h0004
`define SBS_RESP_OKAY 2'b00
`define SBS_RESP_SLVERR 2'b10
`endif

// *** src/sbs_rx_core.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_regs.vh"
// Sixteen-times oversampling receiver; start, false start, idle and frame done are one-cycle pulses, stop_zero and is_break hold until the next frame.
module sbs_rx_core #(
   parameter DIV_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire enable,
   input wire nine_bit,
   input wire [DIV_W-1:0] div,
   input wire rxd,
   output reg start_seen,
   output reg false_start,
   output reg idle_seen,
   output reg frame_done,
   output reg stop_zero,
   output reg is_break,
   output reg [8:0] data
);
   localparam S_IDLE = 2'd0;
   localparam S_START = 2'd1;
   localparam S_DATA = 2'd2;
   localparam S_STOP = 2'd3;
   reg [1:0] st_q;
   reg [DIV_W-1:0] dcnt_q;
   reg [3:0] rt_q;
   reg [3:0] bit_q;
   reg [8:0] sh_q;
   reg all0_q;
   reg [3:0] ones_q;
   wire tick = (dcnt_q == {DIV_W{1'b0}});
   wire [3:0] nbits = nine_bit ? 4'd9 : 4'd8;
   always @(posedge aclk) begin
      if (!aresetn || !enable) begin
         st_q <= S_IDLE;
         dcnt_q <= {DIV_W{1'b0}};
         rt_q <= 4'd0;
         bit_q <= 4'd0;
         sh_q <= 9'd0;
         all0_q <= 1'b0;
         ones_q <= 4'd0;
         start_seen <= 1'b0;
         false_start <= 1'b0;
         idle_seen <= 1'b0;
         frame_done <= 1'b0;
         stop_zero <= 1'b0;
         is_break <= 1'b0;
         data <= 9'd0;
      end else begin
         start_seen <= 1'b0;
         false_start <= 1'b0;
         idle_seen <= 1'b0;
         frame_done <= 1'b0;
         dcnt_q <= tick ? div : dcnt_q - 1'b1;
         if (tick) begin
            rt_q <= rt_q + 1'b1;
            case (st_q)
               S_IDLE: begin
                  rt_q <= 4'd0;
                  if (!rxd) begin
                     st_q <= S_START;
                     rt_q <= 4'd1;
                     start_seen <= 1'b1;
                  end
               end
               S_START: begin
                  if (rt_q == 4'd7) begin
                     if (rxd) begin
                        st_q <= S_IDLE;
                        false_start <= 1'b1;
                     end else begin
                        st_q <= S_DATA;
                        rt_q <= 4'd8;
                        bit_q <= 4'd0;
                        all0_q <= 1'b1;
                        ones_q <= 4'd0;
                     end
                  end
               end
               S_DATA: begin
                  if (rt_q == 4'd7) begin
                     sh_q <= {rxd, sh_q[8:1]};
                     all0_q <= all0_q & ~rxd;
                     ones_q <= rxd ? ones_q + 1'b1 : ones_q;
                     bit_q <= bit_q + 1'b1;
                     if (bit_q + 1'b1 == nbits)
                        st_q <= S_STOP;
                  end
               end
               S_STOP: begin
                  if (rt_q == 4'd7) begin
                     st_q <= S_IDLE;
                     frame_done <= 1'b1;
                     stop_zero <= ~rxd;
                     is_break <= all0_q & ~rxd;
                     idle_seen <= rxd & (ones_q == nbits);
                     data <= nine_bit ? sh_q : {1'b0, sh_q[8:1]};
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** src/sbs_status.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_regs.vh"
module sbs_status #(
   parameter DIV_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire rxd,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   function [7:0] word_idx;
      input [31:0] a;
      begin
         word_idx = a[9:2];
      end
   endfunction
   // Receive status flags, one register each so that set and clear paths stay apart.
   reg break_seen_flag_q;
   reg rx_in_progress_flag_q;
   reg framing_error_flag_q;
   reg receive_full_flag_q;
   reg received_ninth_bit_q;
   // Break detection is armed again once the line has been seen high.
   reg armed_q;
   // Pending-clear marks: the status read has been seen, a data read completes the clear.
   reg brk_rd_q;
   reg err_rd_q;
   reg nine_q;
   reg en_q;
   reg [DIV_W-1:0] div_q;
   reg [7:0] data_q;
   reg aw_q;
   reg w_q;
   reg [31:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   wire start_seen;
   wire false_start;
   wire idle_seen;
   wire frame_done;
   wire stop_zero;
   wire is_break;
   wire [8:0] rx_data;
   sbs_rx_core #(.DIV_W(DIV_W)) u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(en_q),
      .nine_bit(nine_q),
      .div(div_q),
      .rxd(rxd),
      .start_seen(start_seen),
      .false_start(false_start),
      .idle_seen(idle_seen),
      .frame_done(frame_done),
      .stop_zero(stop_zero),
      .is_break(is_break),
      .data(rx_data)
   );
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire [7:0] ridx = word_idx(s_axi_araddr);
   wire rd_s2 = rd_go && ridx == `SBS_IDX_STATUS_TWO;
   wire rd_s1 = rd_go && ridx == `SBS_IDX_STATUS_ONE;
   wire rd_dr = rd_go && ridx == `SBS_IDX_DATA;
   wire brk_ev = frame_done && is_break && armed_q;
   wire wr_go = aw_q && w_q && !s_axi_bvalid;
   wire [7:0] widx = word_idx(awaddr_q);
   // The control word is written only when the latched strobe enables its low byte lane.
   wire ctl_wr = wr_go && (widx == `SBS_IDX_RX_CTRL) && wstrb_q[0];
   wire [7:0] st2 = {6'd0, break_seen_flag_q, rx_in_progress_flag_q};
   wire [7:0] st1 = {2'd0, receive_full_flag_q, 3'd0, framing_error_flag_q, 1'b0};
   wire [7:0] c3 = {received_ninth_bit_q, 7'd0};
   wire [7:0] ctl = {6'd0, en_q, nine_q};
   always @(posedge aclk) begin
      if (!aresetn) begin
         break_seen_flag_q <= 1'b0;
         rx_in_progress_flag_q <= 1'b0;
         framing_error_flag_q <= 1'b0;
         receive_full_flag_q <= 1'b0;
         received_ninth_bit_q <= 1'b0;
         armed_q <= 1'b1;
         brk_rd_q <= 1'b0;
         err_rd_q <= 1'b0;
         data_q <= 8'h00;
         nine_q <= 1'b0;
         en_q <= 1'b0;
         div_q <= `SBS_RESET_DIV;
      end else begin
         // Progress flag is status only and feeds no interrupt.
         if (start_seen)
            rx_in_progress_flag_q <= 1'b1;
         else if (false_start || idle_seen || frame_done || !en_q)
            rx_in_progress_flag_q <= 1'b0;
         if (rd_s2 && break_seen_flag_q)
            brk_rd_q <= 1'b1;
         if (rd_s1 && framing_error_flag_q)
            err_rd_q <= 1'b1;
         if (rd_dr && brk_rd_q) begin
            break_seen_flag_q <= 1'b0;
            brk_rd_q <= 1'b0;
         end
         if (rd_dr && err_rd_q) begin
            framing_error_flag_q <= 1'b0;
            err_rd_q <= 1'b0;
         end
         if (rd_dr)
            receive_full_flag_q <= 1'b0;
         if (frame_done && !is_break) begin
            receive_full_flag_q <= 1'b1;
            data_q <= rx_data[7:0];
            received_ninth_bit_q <= rx_data[8];
         end
         if (frame_done && stop_zero)
            framing_error_flag_q <= 1'b1;
         // Any high level on the line rearms break detection, so a break that follows a
         // short high gap is still reported even when no whole frame came in between.
         if (rxd)
            armed_q <= 1'b1;
         // Break has no interrupt path at all; sets win over same-cycle clears.
         if (brk_ev) begin
            break_seen_flag_q <= 1'b1;
            framing_error_flag_q <= 1'b1;
            receive_full_flag_q <= 1'b1;
            data_q <= 8'h00;
            armed_q <= 1'b0;
            if (nine_q)
               received_ninth_bit_q <= 1'b0;
         end
         if (ctl_wr) begin
            nine_q <= wdata_q[`SBS_BIT_NINE];
            en_q <= wdata_q[`SBS_BIT_EN];
            div_q <= wdata_q[DIV_W+7:8];
         end
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SBS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SBS_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (widx == `SBS_IDX_RX_CTRL) ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SBS_RESP_OKAY;
            case (ridx)
               `SBS_IDX_STATUS_TWO: s_axi_rdata <= {24'd0, st2};
               `SBS_IDX_STATUS_ONE: s_axi_rdata <= {24'd0, st1};
               `SBS_IDX_DATA: s_axi_rdata <= {24'd0, data_q};
               `SBS_IDX_CONTROL_THREE: s_axi_rdata <= {24'd0, c3};
               `SBS_IDX_RX_CTRL: s_axi_rdata <= {{(24-DIV_W){1'b0}}, div_q, ctl};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SBS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** test/sbs_status_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_regs.vh"
module sbs_status_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rxd,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [31:0] aw_q;
   logic [31:0] ar_q;
   logic [9:0] hi_q;
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arready) ar_q <= s_axi_araddr;
      if (!aresetn || !rxd) hi_q <= 10'h000;
      else if (hi_q != 10'h3ff) hi_q <= hi_q + 10'h001;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid
      && s_axi_rdata == 32'h0000_0000) else $error("outputs busy after reset");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_ro_write: assert property (s_axi_bvalid |-> s_axi_bresp ==
      (aw_q == 32'h0000_0068 ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR)) else $error("bad write response");
   a_unmapped_read: assert property (s_axi_rvalid && (ar_q < 32'h0000_0058 || ar_q > 32'h0000_0068)
      |-> s_axi_rresp == `SBS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
   a_status_bits: assert property (s_axi_rvalid && ar_q == 32'h0000_005c |->
      s_axi_rdata[31:2] == 30'h0 && s_axi_rresp == `SBS_RESP_OKAY) else $error("status bits");
   a_read_latency: assert property (s_axi_arready |=> s_axi_rvalid) else $error("late read");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("late write");
   a_idle_clear: assert property (s_axi_rvalid && ar_q == 32'h0000_005c && hi_q == 10'h3ff
      |-> !s_axi_rdata[0]) else $error("progress set on idle line");
   cover property (s_axi_rvalid && ar_q == 32'h0000_005c && s_axi_rdata[1]);
   cover property (s_axi_rvalid && ar_q == 32'h0000_005c && s_axi_rdata[0]);
   cover property (s_axi_bvalid && s_axi_bresp == `SBS_RESP_SLVERR);
endmodule
`default_nettype wire

// *** test/sbs_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbs_tx_model #(
   parameter int BIT_CLKS = 80
) (
   input wire logic aclk,
   output var logic rxd
);
   initial rxd = 1'b1;
   task automatic hold(input logic v);
      rxd <= v;
      @(posedge aclk);
   endtask
   // Start, nine data bits first bit lowest, stop; the line stays at the stop level.
   task automatic send_frame(input logic [8:0] v, input logic stop);
      logic [10:0] f;
      f = {stop, v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (BIT_CLKS) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

// *** test/sbs_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_regs.vh"
module sbs_status_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   wire logic rxd;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [8:0] byt;
   logic [3:0] wstrb = 4'hf;
   int err_count = 0, num_checks = 0, cyc = 0, brk_exp = 0;
   logic [8:0] q[$];
   sbs_tx_model #(.BIT_CLKS(80)) i_sbs_tx_model (.aclk(aclk), .rxd(rxd));
   sbs_status #(.DIV_W(16)) i_sbs_status (.aclk(aclk), .aresetn(aresetn), .rxd(rxd),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   initial forever #12.5 aclk = ~aclk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   initial begin
      void'($urandom(32'h59df_4704));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(32'h0000_005c);
      chk(d, 32'h0000_0000);
      rd(32'h0000_0000);
      chk(r, `SBS_RESP_SLVERR);
      wr(32'h0000_005c, 32'h0000_0003);
      chk(r, `SBS_RESP_SLVERR);
      // Divider 4, receiver on, nine-bit characters.
      wr(32'h0000_0068, 32'h0000_0403);
      chk(r, `SBS_RESP_OKAY);
      // A write with no byte lane enabled must leave the control word alone.
      wstrb <= 4'h0;
      wr(32'h0000_0068, 32'h0000_0000);
      wstrb <= 4'hf;
      chk(r, `SBS_RESP_OKAY);
      rd(32'h0000_0068);
      chk(d, 32'h0000_0403);
      byt = $urandom;
      byt[8] = 1'b1;
      q.push_back(byt);
      fork
         i_sbs_tx_model.send_frame(byt, 1'b1);
         begin
            repeat (240) @(posedge aclk);
            rd(32'h0000_005c);
            chk(d[0], 1'b1);
         end
      join
      repeat (1100) @(posedge aclk);
      rd(32'h0000_005c);
      chk(d, 32'h0000_0000);
      rd(32'h0000_0064);
      chk(d[7], 1'b1);
      rd(32'h0000_0060);
      byt = q.pop_front();
      chk(d[7:0], byt[7:0]);
      i_sbs_tx_model.send_frame(9'h000, 1'b0);
      brk_exp = 1;
      repeat (20) @(posedge aclk);
      rd(32'h0000_0058);
      chk(d & 32'h0000_0022, 32'h0000_0022);
      rd(32'h0000_0064);
      chk(d[7], 1'b0);
      rd(32'h0000_005c);
      chk(d[1], brk_exp[0]);
      rd(32'h0000_0060);
      chk(d, 32'h0000_0000);
      brk_exp = 0;
      repeat (1700) @(posedge aclk);
      rd(32'h0000_005c);
      chk(d[1], brk_exp[0]);
      i_sbs_tx_model.hold(1'b1);
      repeat (1100) @(posedge aclk);
      i_sbs_tx_model.send_frame(9'h000, 1'b0);
      i_sbs_tx_model.hold(1'b1);
      brk_exp = 1;
      repeat (1100) @(posedge aclk);
      rd(32'h0000_005c);
      chk(d, 32'(brk_exp * 2));
      i_sbs_tx_model.hold(1'b0);
      repeat (20) @(posedge aclk);
      i_sbs_tx_model.hold(1'b1);
      repeat (1100) @(posedge aclk);
      rd(32'h0000_005c);
      chk(d[0], 1'b0);
      // Switch the receiver off only once no reception is under way.
      do rd(32'h0000_005c); while (d[0]);
      wr(32'h0000_0068, 32'h0000_0400);
      chk(r, `SBS_RESP_OKAY);
      rd(32'h0000_005c);
      chk(d, 32'(brk_exp * 2));
      end_of_test();
   end
endmodule
bind sbs_status sbs_status_chk i_sbs_status_chk (.aclk(aclk), .aresetn(aresetn), .rxd(rxd),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire
